// File: design/hio_dev.sv
`default_nettype none
// ***********************************************************
// Processor end: control word, host interrupts, device select, table
// ***********************************************************
module hio_dev #(
  parameter int unsigned TBL_AW = 4,
  parameter int unsigned TBL_W  = 16
) (
  input  wire logic              clk_i,            // System clock
  input  wire logic              rst_i,            // Sync reset, high
  hio_link_if.dev                link,             // Host link
  input  wire logic              proc_load_device_select_op_i,      // Load device select op
  input  wire logic              proc_out_i,       // Output op to selected device
  input  wire logic [15:0]       proc_data_i,      // Processor data bus
  input  wire logic              proc_raise_sig_i, // Raise host signal op
  input  wire logic              proc_halted_i,    // Processor halted
  input  wire logic              dma_done_i,       // DMA transfer finished
  input  wire logic [TBL_AW-1:0] tbl_ptr_i,        // Table address pointer
  output logic [TBL_W-1:0]       tbl_out_o,        // Table output latch
  output logic [7:0]             dev_sel_o,        // Device select value
  output logic [4:0]             sel_class_o,      // Decoded device class
  output logic                   dma_go_o,         // DMA go bit
  output logic [6:0]             dma_ctl_o,        // DMA control bits
  output logic                   sig_pend_o        // Signal condition pending
);
  localparam int unsigned TBL_N = 1 << TBL_AW;

  typedef struct packed {
    logic [15:0]                  ctl;
    logic [7:0]                   dsel;
    logic [4:0]                   cls;
    logic                         sig;
    logic                         irq;
    logic [TBL_N-1:0][TBL_W-1:0]  ram;
    logic [TBL_W-1:0]             stg;
    logic [TBL_W-1:0]             tout;
  } hio_dev_st_t;

  hio_dev_st_t st_ff;
  hio_dev_st_t nxt_st;

  // Classify a device select value
  function automatic logic [4:0] hio_decode(input logic [7:0] ds);
    logic [4:0] c;
    c = '0;
    c[hio_pkg::CLS_HOST]  = (ds <= hio_pkg::DS_HOST_LAST) && (ds != hio_pkg::DS_TABLE);
    c[hio_pkg::CLS_TABLE] = (ds == hio_pkg::DS_TABLE);
    c[hio_pkg::CLS_BANK]  = (ds == hio_pkg::DS_BANK_0) || (ds == hio_pkg::DS_BANK_1);
    c[hio_pkg::CLS_IOP1]  = (ds >= hio_pkg::DS_IOP1_LO) && (ds <= hio_pkg::DS_IOP1_HI);
    c[hio_pkg::CLS_IOP2]  = (ds >= hio_pkg::DS_IOP2_LO) && (ds <= hio_pkg::DS_IOP2_HI);
    return c;
  endfunction

  // Merge a control write; go can only be set, signal bit by choice
  function automatic logic [15:0] hio_ctl_merge(input logic [15:0] cur,
                                                input logic [15:0] wd,
                                                input logic        keep_sig);
    logic [15:0] r;
    r = wd;
    r[hio_pkg::POS_GO] = cur[hio_pkg::POS_GO] | wd[hio_pkg::POS_GO];
    if (keep_sig) begin
      r[hio_pkg::POS_SIG_EN] = cur[hio_pkg::POS_SIG_EN];
    end
    return r;
  endfunction

  logic proc_ctl_wr;
  logic proc_tbl_wr;
  logic set_sig;
  logic clr_sig;
  logic [2:0] src;

  // ***********************************************************
  // Next state
  // ***********************************************************
  always_comb begin
    nxt_st = st_ff;
    proc_ctl_wr = proc_out_i && (st_ff.dsel == hio_pkg::DS_CTL);
    proc_tbl_wr = proc_out_i && st_ff.cls[hio_pkg::CLS_TABLE];
    // Signal condition: processor attempt sets only with enable already on
    set_sig = st_ff.ctl[hio_pkg::POS_SIG_EN] &&
              (proc_raise_sig_i || (proc_ctl_wr && proc_data_i[hio_pkg::POS_SIG_EN]));
    clr_sig = link.fn_wr || (proc_ctl_wr && !proc_data_i[hio_pkg::POS_SIG_EN]);
    if (set_sig) begin
      nxt_st.sig = 1'b1;
    end else if (clr_sig) begin
      nxt_st.sig = 1'b0;
    end
    // Control word: DMA finish drops go, writes follow
    if (dma_done_i) begin
      nxt_st.ctl[hio_pkg::POS_GO] = 1'b0;
    end
    if (link.ctl_wr) begin
      nxt_st.ctl = hio_ctl_merge(nxt_st.ctl, link.ctl_wdata, 1'b0);
    end else if (proc_ctl_wr) begin
      nxt_st.ctl = hio_ctl_merge(nxt_st.ctl, proc_data_i, 1'b1);
    end
    // Device select load and decode
    if (proc_load_device_select_op_i) begin
      nxt_st.dsel = proc_data_i[7:0];
    end
    nxt_st.cls = hio_decode(nxt_st.dsel);
    // Table write, then two-stage output path
    if (proc_tbl_wr) begin
      nxt_st.ram[tbl_ptr_i] = proc_data_i[TBL_W-1:0];
    end
    nxt_st.stg  = st_ff.ram[tbl_ptr_i];
    nxt_st.tout = st_ff.stg;
    // Host request: enabled sources ORed, level follows enables
    src[0] = nxt_st.ctl[hio_pkg::POS_HALT_EN] && proc_halted_i;
    src[1] = nxt_st.ctl[hio_pkg::POS_IDLE_EN] && !nxt_st.ctl[hio_pkg::POS_GO];
    src[2] = nxt_st.ctl[hio_pkg::POS_SIG_EN] && nxt_st.sig;
    nxt_st.irq = |src;
    if (rst_i) begin
      nxt_st      = '0;
      nxt_st.ctl  = hio_pkg::CTL_RESET;
      nxt_st.dsel = hio_pkg::DS_RESET;
      nxt_st.cls  = hio_decode(hio_pkg::DS_RESET);
    end
  end

  // ***********************************************************
  // State register
  // ***********************************************************
  always_ff @(posedge clk_i) begin
    st_ff <= nxt_st;
  end

  // Outputs straight from state
  assign link.ctl_rdata = st_ff.ctl;
  assign link.irq       = st_ff.irq;
  assign tbl_out_o      = st_ff.tout;
  assign dev_sel_o      = st_ff.dsel;
  assign sel_class_o    = st_ff.cls;
  assign dma_go_o       = st_ff.ctl[hio_pkg::POS_GO];
  assign dma_ctl_o      = st_ff.ctl[hio_pkg::POS_DMA_HI:hio_pkg::POS_DMA_LO];
  assign sig_pend_o     = st_ff.sig;
endmodule
`default_nettype wire

// File: design/hio_host.sv
`default_nettype none
// ***********************************************************
// Host end: Wishbone slave driving the link
// ***********************************************************
module hio_host (
  input  wire logic        clk_i,   // System clock
  input  wire logic        rst_i,   // Sync reset, high
  hio_link_if.host         link,    // Link to processor end
  input  wire logic        cyc_i,   // Wishbone cycle
  input  wire logic        stb_i,   // Wishbone strobe
  input  wire logic        we_i,    // Wishbone write
  input  wire logic [3:0]  adr_i,   // Wishbone byte address
  input  wire logic [3:0]  sel_i,   // Wishbone byte lanes
  input  wire logic [31:0] dat_i,   // Wishbone write data
  output logic [31:0]      dat_o,   // Wishbone read data
  output logic             ack_o,   // Wishbone acknowledge
  output logic             irq_o    // Host interrupt copy
);
  typedef struct packed {
    logic        ack;
    logic [31:0] rdat;
    logic        ctl_wr;
    logic        fn_wr;
    logic [15:0] wdat;
    logic [15:0] fn;
    logic        irq;
  } hio_host_st_t;

  hio_host_st_t st_ff;
  hio_host_st_t nxt_st;
  logic         req;
  logic [15:0]  lane_data;

  // ***********************************************************
  // Next state
  // ***********************************************************
  always_comb begin
    nxt_st        = st_ff;
    req           = cyc_i && stb_i && !st_ff.ack;
    lane_data     = dat_i[15:0];
    nxt_st.ack    = req;
    nxt_st.ctl_wr = 1'b0;
    nxt_st.fn_wr  = 1'b0;
    nxt_st.irq    = link.irq;
    if (req && we_i && (sel_i[1:0] == 2'b11)) begin
      nxt_st.wdat = lane_data;
      if (adr_i == hio_pkg::HREG_CTL) begin
        nxt_st.ctl_wr = 1'b1;
      end
      if (adr_i == hio_pkg::HREG_FN) begin
        nxt_st.fn_wr = 1'b1;
        nxt_st.fn    = lane_data;
      end
    end
    if (req && !we_i) begin
      unique case (adr_i)
        hio_pkg::HREG_CTL:  nxt_st.rdat = {16'h0000, link.ctl_rdata};
        hio_pkg::HREG_FN:   nxt_st.rdat = {16'h0000, st_ff.fn};
        hio_pkg::HREG_STAT: nxt_st.rdat = {31'h00000000, link.irq};
        default:            nxt_st.rdat = 32'h00000000;
      endcase
    end
    if (rst_i) begin
      nxt_st = '0;
    end
  end

  // ***********************************************************
  // State register
  // ***********************************************************
  always_ff @(posedge clk_i) begin
    st_ff <= nxt_st;
  end

  // Outputs straight from state
  assign dat_o          = st_ff.rdat;
  assign ack_o          = st_ff.ack;
  assign irq_o          = st_ff.irq;
  assign link.ctl_wr    = st_ff.ctl_wr;
  assign link.fn_wr     = st_ff.fn_wr;
  assign link.ctl_wdata = st_ff.wdat;
  assign link.fn_wdata  = st_ff.wdat;
endmodule
`default_nettype wire

// File: design/hio_link_if.sv
`default_nettype none
// ***********************************************************
// Host to processor link
// ***********************************************************
interface hio_link_if;
  logic        ctl_wr;    // Host control write strobe
  logic [15:0] ctl_wdata; // Host control write data
  logic        fn_wr;     // Host function write strobe
  logic [15:0] fn_wdata;  // Host function write data
  logic [15:0] ctl_rdata; // Control word as read
  logic        irq;       // Host interrupt request
  modport dev  (input ctl_wr, ctl_wdata, fn_wr, fn_wdata, output ctl_rdata, irq);
  modport host (output ctl_wr, ctl_wdata, fn_wr, fn_wdata, input ctl_rdata, irq);
endinterface
`default_nettype wire

// File: design/hio_pkg.sv
`default_nettype none
package hio_pkg;
  // ***********************************************************
  // Control word field positions (bit n is position 15 - n)
  // ***********************************************************
  localparam int unsigned CTL_W        = 16;
  localparam int unsigned POS_HALT_EN  = 12;
  localparam int unsigned POS_IDLE_EN  = 11;
  localparam int unsigned POS_SIG_EN   = 10;
  localparam int unsigned POS_DMA_LO   = 1;
  localparam int unsigned POS_DMA_HI   = 7;
  localparam int unsigned POS_GO       = 0;
  localparam logic [15:0] CTL_RESET    = 16'h0000;
  // ***********************************************************
  // Device select codes
  // ***********************************************************
  localparam int unsigned DS_W         = 8;
  localparam logic [7:0]  DS_RESET     = 8'h00;
  localparam logic [7:0]  DS_CTL       = 8'h02;
  localparam logic [7:0]  DS_TABLE     = 8'h05;
  localparam logic [7:0]  DS_HOST_LAST = 8'h06;
  localparam logic [7:0]  DS_BANK_0    = 8'h18;
  localparam logic [7:0]  DS_BANK_1    = 8'h19;
  localparam logic [7:0]  DS_IOP1_LO   = 8'h08;
  localparam logic [7:0]  DS_IOP1_HI   = 8'h0c;
  localparam logic [7:0]  DS_IOP2_LO   = 8'h10;
  localparam logic [7:0]  DS_IOP2_HI   = 8'h14;
  // Decoded class bits
  localparam int unsigned CLS_HOST     = 0;
  localparam int unsigned CLS_TABLE    = 1;
  localparam int unsigned CLS_BANK     = 2;
  localparam int unsigned CLS_IOP1     = 3;
  localparam int unsigned CLS_IOP2     = 4;
  localparam int unsigned CLS_W        = 5;
  // ***********************************************************
  // Host-side register offsets
  // ***********************************************************
  localparam logic [3:0]  HREG_CTL     = 4'h0;
  localparam logic [3:0]  HREG_FN      = 4'h4;
  localparam logic [3:0]  HREG_STAT    = 4'h8;
endpackage
`default_nettype wire

// File: verification/hio_link_asserts.sv
`default_nettype none
// ********
// Link checker
// ********
module hio_link_asserts (
  input wire logic        clk_i,     // System clock
  input wire logic        rst_i,     // Sync reset
  input wire logic        ctl_wr,    // Host control write
  input wire logic [15:0] ctl_wdata, // Control write data
  input wire logic        fn_wr,     // Host function write
  input wire logic [15:0] ctl_rdata, // Control word
  input wire logic        irq        // Host request
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Idle source armed, and host start of DMA
  sequence s_idle_armed;
    ctl_rdata[11] && !ctl_rdata[0];
  endsequence
  sequence s_go_write;
    ctl_wr && ctl_wdata[0];
  endsequence
  chk_irq_needs_en: assert property (irq |-> ctl_rdata[12:10] != 3'h0)
    else $error("request with no enable set");
  chk_no_en_quiet: assert property (ctl_rdata[12:10] == 3'h0 |-> !irq)
    else $error("request while enables clear");
  chk_idle_raises: assert property (s_idle_armed ##1 s_idle_armed |-> irq)
    else $error("idle source not raised");
  chk_go_starts: assert property (s_go_write |=> ctl_rdata[0])
    else $error("go not set");
  chk_go_zero_keeps: assert property (ctl_wr && !ctl_wdata[0] && ctl_rdata[0] |=> ctl_rdata[0])
    else $error("running DMA stopped");
  chk_ctl_stores: assert property (ctl_wr |=> ctl_rdata[15:1] == $past(ctl_wdata[15:1]))
    else $error("control write lost");
  chk_fn_pulse: assert property (fn_wr |=> !fn_wr)
    else $error("function strobe too long");
  chk_wr_exclusive: assert property (!(ctl_wr && fn_wr))
    else $error("two host strobes");
endmodule
`default_nettype wire

// File: verification/test_host_interrupt_and_io_select.sv
`default_nettype none
module test_host_interrupt_and_io_select;
  timeunit 1ns;
  timeprecision 1ps;
  // ********
  // Bench
  // ********
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, irq_o;
  logic        load_device_select_op = 1'b0, pout = 1'b0, raise = 1'b0, halted = 1'b0, done = 1'b0, go, sig;
  logic [3:0]  adr = 4'h0, ptr = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic [15:0] data = 16'h0, tbl;
  logic [7:0]  dsel;
  logic [6:0]  dctl;
  logic [4:0]  cls;
  int          fail_count = 0, cmp_count = 0, cycles = 0;
  hio_link_if link ();
  hio_dev u_hio_dev (.clk_i(clk_i), .rst_i(rst_i), .link(link), .proc_load_device_select_op_i(load_device_select_op),
    .proc_out_i(pout), .proc_data_i(data), .proc_raise_sig_i(raise), .proc_halted_i(halted),
    .dma_done_i(done), .tbl_ptr_i(ptr), .tbl_out_o(tbl), .dev_sel_o(dsel), .sel_class_o(cls),
    .dma_go_o(go), .dma_ctl_o(dctl), .sig_pend_o(sig));
  hio_host u_hio_host (.clk_i(clk_i), .rst_i(rst_i), .link(link), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .irq_o(irq_o));
  hio_link_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i), .ctl_wr(link.ctl_wr),
    .ctl_wdata(link.ctl_wdata), .fn_wr(link.fn_wr), .ctl_rdata(link.ctl_rdata), .irq(link.irq));
  // Clock and hang guard
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles > 20000) begin
      fail_count++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // Classic Wishbone single cycle, held until ack
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // One processor cycle of ops
  task automatic pop(input logic l, input logic o, input logic r, input logic [15:0] d);
    @(posedge clk_i);
    load_device_select_op <= l;
    pout <= o;
    raise <= r;
    data <= d;
    @(posedge clk_i);
    load_device_select_op <= 1'b0;
    pout <= 1'b0;
    raise <= 1'b0;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  function automatic logic [4:0] exp_cls(input logic [7:0] v);
    exp_cls = {v >= 8'h10 && v <= 8'h14, v >= 8'h08 && v <= 8'h0c, v == 8'h18 || v == 8'h19,
               v == 8'h05, v <= 8'h04 || v == 8'h06};
  endfunction
  task automatic t_halt();
    halted <= 1'b1;
    wb(1'b1, hio_pkg::HREG_CTL, 32'h1000);
    settle(3);
    chk(32'(irq_o), 32'h1, "halt request");
    wb(1'b0, hio_pkg::HREG_STAT, 32'h0);
    chk(32'(q[0]), 32'h1, "status request");
    halted <= 1'b0;
    settle(3);
    chk(32'(irq_o), 32'h0, "halt gone");
    wb(1'b0, 4'hc, 32'h0);
    chk(q, 32'h0, "unmapped read");
    $display("halt test done");
  endtask
  task automatic t_idle();
    wb(1'b1, hio_pkg::HREG_CTL, 32'h0803);
    settle(3);
    chk(32'({go, irq_o}), 32'h2, "running quiet");
    wb(1'b1, hio_pkg::HREG_CTL, 32'h0802);
    settle(3);
    chk(32'({go, irq_o, dctl}), 32'h101, "go kept");
    @(posedge clk_i);
    done <= 1'b1;
    @(posedge clk_i);
    done <= 1'b0;
    settle(3);
    chk(32'({go, irq_o}), 32'h1, "idle request");
    wb(1'b0, hio_pkg::HREG_CTL, 32'h0);
    chk(32'(q[15:0]), 32'h0802, "go reads idle");
    $display("idle test done");
  endtask
  task automatic t_signal();
    wb(1'b1, hio_pkg::HREG_CTL, 32'h0);
    pop(1'b0, 1'b0, 1'b1, 16'h0);
    settle(2);
    chk(32'(sig), 32'h0, "raise without enable");
    wb(1'b1, hio_pkg::HREG_CTL, 32'h0400);
    pop(1'b0, 1'b0, 1'b1, 16'h0);
    settle(3);
    chk(32'({sig, irq_o}), 32'h3, "raise op");
    wb(1'b1, hio_pkg::HREG_FN, 32'h0);
    settle(3);
    chk(32'({sig, irq_o}), 32'h0, "function clears");
    pop(1'b1, 1'b0, 1'b0, 16'h0002);
    pop(1'b0, 1'b1, 1'b0, 16'h0400);
    settle(3);
    chk(32'({sig, irq_o}), 32'h3, "processor write raises");
    wb(1'b1, hio_pkg::HREG_CTL, 32'h0);
    settle(3);
    chk(32'(irq_o), 32'h0, "enables cleared");
    wb(1'b1, hio_pkg::HREG_CTL, 32'h0400);
    settle(3);
    chk(32'(irq_o), 32'h1, "enable again");
    pop(1'b0, 1'b1, 1'b0, 16'h0);
    settle(3);
    chk(32'({sig, irq_o}), 32'h0, "zero write clears");
    wb(1'b0, hio_pkg::HREG_CTL, 32'h0);
    chk(32'(q[15:0]), 32'h0400, "enable kept");
    $display("signal test done");
  endtask
  task automatic t_select();
    for (int v = 0; v < 256; v++) begin
      pop(1'b1, 1'b0, 1'b0, 16'(v));
      settle(2);
      chk(32'(dsel), 32'(v), "select");
      chk(32'(cls), 32'(exp_cls(8'(v))), "class");
    end
    pop(1'b1, 1'b0, 1'b0, 16'h0005);
    ptr <= 4'h3;
    pop(1'b0, 1'b1, 1'b0, 16'ha5c3);
    settle(2);
    chk(32'(tbl), 32'ha5c3, "table write");
    $display("select test done");
  endtask
  // Start DMA first, then enable by read-modify-write, then service the request
  task automatic t_service();
    wb(1'b1, hio_pkg::HREG_CTL, 32'h0001);
    wb(1'b0, hio_pkg::HREG_CTL, 32'h0);
    wb(1'b1, hio_pkg::HREG_CTL, (q & 32'h0000fffe) | 32'h0800);
    settle(3);
    chk(32'({go, irq_o}), 32'h2, "enable while running");
    @(posedge clk_i);
    done <= 1'b1;
    @(posedge clk_i);
    done <= 1'b0;
    settle(3);
    chk(32'(irq_o), 32'h1, "idle after start");
    wb(1'b0, hio_pkg::HREG_STAT, 32'h0);
    chk(32'(q[0]), 32'h1, "service sees request");
    wb(1'b0, hio_pkg::HREG_CTL, 32'h0);
    chk(32'(q[15:0] & 16'h1801), 32'h0800, "poll finds idle");
    wb(1'b1, hio_pkg::HREG_CTL, 32'h0);
    wb(1'b1, hio_pkg::HREG_FN, 32'h0);
    settle(3);
    chk(32'(irq_o), 32'h0, "serviced quiet");
    $display("service test done");
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_halt();
    t_idle();
    t_signal();
    t_select();
    t_service();
    report_and_stop();
  end
endmodule
`default_nettype wire
